/* File: fsrl_pkg.sv */
// Shared constants and types of the flash status register logic
package fsrl_pkg;

  // Status command opcodes
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_BYTE1 = 8'h01;
  localparam logic [7:0] OP_WRITE_BYTE2 = 8'h31;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

  // Field positions, first status byte
  localparam int B1_LOCK = 7;
  localparam int B1_FAIL = 5;
  localparam int B1_GUARD = 4;
  localparam int B1_SWP_HI = 3;
  localparam int B1_SWP_LO = 2;
  localparam int B1_LATCH = 1;
  localparam int B1_BUSY = 0;

  // Field positions, second status byte
  localparam int B2_RSV_HI = 7;
  localparam int B2_RSV_LO = 5;
  localparam int B2_RST_PERMIT = 4;
  localparam int B2_LD_PERMIT = 3;
  localparam int B2_PROG_PAUSED = 2;
  localparam int B2_ERASE_PAUSED = 1;
  localparam int B2_BUSY = 0;

  // Power-up values
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_FAIL = 1'b0;
  localparam logic RST_LATCH = 1'b0;
  localparam logic RST_RST_PERMIT = 1'b0;
  localparam logic RST_LD_PERMIT = 1'b0;
  localparam logic RST_PAUSED = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Bit count that completes a byte
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    FSRL_IDLE,
    FSRL_OPCODE,
    FSRL_READ,
    FSRL_DATA,
    FSRL_SKIP
  } fsrl_state_t;

endpackage

/* File: fsrl_link_sync.sv */
// Pin synchroniser and serial clock edge finder
`timescale 1ns/1ns
module fsrl_link_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic sck_rise_o,
  output logic sck_fall_o,
  output logic cs_n_o,
  output logic si_o,
  output logic wp_n_o
);

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic sck_last;
  } fsrl_sync_t;

  fsrl_sync_t q;
  fsrl_sync_t d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.meta = {sck_i, cs_n_i, si_i, wp_n_i};
    d.sync = q.meta;
    d.sck_last = q.sync[3];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{meta: 4'h5, sync: 4'h5, sck_last: 1'b0};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sck_rise_o = q.sync[3] & ~q.sck_last;
  assign sck_fall_o = ~q.sync[3] & q.sck_last;
  assign cs_n_o = q.sync[2];
  assign si_o = q.sync[1];
  assign wp_n_o = q.sync[0];

endmodule

/* File: fsrl_status_regs.sv */
// Two-byte status register with its serial read and write commands
`timescale 1ns/1ns
// Overview of operation
// - Byte-two write changes only bits 4, 3
// - Byte-two bits 7..5 read zero
// - Bit 4 permits the reset command
// - Bit 3 permits lockdown and freeze commands
// - Bits 2, 1 show program/erase suspended
// - Bit 0 mirrors busy
// - Lock blocks sector protect changes
// - Lock clears at power-up, reset ignores it
// - Guard pin asserted: lock may only set
// - Byte-one write changes only the lock
// - Failed erase or program sets fail flag
// - Aborts never set the fail flag
// - Read-only bit shows guard pin level
// - Two bits summarise software protection
// - Clear latch rejects status writes and lockdown; reset is not gated by it
// - Latch clears at power-up and reset
// - Latch clears on disable, op end, hold
// - Partial opcode leaves latch untouched
// - Reset permit changes only by write
// - Lockdown permit changes only by write or freeze
// - Freeze forces lockdown permit to zero
// - Read status streams both bytes repeatedly
// - Byte-two write applies on aligned deselect
// - Soft reset clears latch and suspends
module fsrl_status_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic op_busy_i,
  input wire logic op_end_i,
  input wire logic op_fail_i,
  input wire logic latch_clear_i,
  input wire logic hold_abort_i,
  input wire logic soft_reset_i,
  input wire logic freeze_done_i,
  input wire logic prog_suspend_i,
  input wire logic prog_resume_i,
  input wire logic erase_suspend_i,
  input wire logic erase_resume_i,
  input wire logic [1:0] soft_protect_summary_i,
  output logic so_o,
  output logic so_oe_o,
  output logic [7:0] status_byte_one_o,
  output logic [7:0] status_byte_two_o,
  output logic protect_regs_lock_o,
  output logic write_latch_o,
  output logic soft_reset_permit_o,
  output logic lockdown_permit_o,
  output logic protect_change_ok_o,
  output logic lockdown_cmd_ok_o,
  output logic reset_cmd_ok_o,
  output logic global_protect_o
);

  typedef struct packed {
    fsrl_pkg::fsrl_state_t st;
    logic [2:0] bit_cnt;
    logic [7:0] opcode;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] wdata;
    logic byte_sel, data_seen;
    logic lock, fail, latch;
    logic rst_permit, ld_permit, frozen;
    logic prog_paused, erase_paused;
    logic so, so_oe;
    logic [7:0] stat1, stat2;
    logic prot_ok, ld_ok, rst_ok, gprot;
  } fsrl_regs_t;

  fsrl_regs_t q;
  fsrl_regs_t d;

  logic sck_rise, sck_fall, cs_n_s, si_s, wp_n_s;
  logic [7:0] img1, img2, rx_next;
  logic frame_end, full_op, aligned, wren_set;
  logic wr1_apply, wr2_apply, wr_clear, reset_ok;

  ////////////////////////////////////////////////////////////////////////////
  fsrl_link_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .wp_n_i(wp_n_i),
    .sck_rise_o(sck_rise),
    .sck_fall_o(sck_fall),
    .cs_n_o(cs_n_s),
    .si_o(si_s),
    .wp_n_o(wp_n_s)
  );

  function automatic logic is_write_cmd(input logic [7:0] op);
    is_write_cmd = (op == fsrl_pkg::OP_WRITE_BYTE1) || (op == fsrl_pkg::OP_WRITE_BYTE2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status images and frame-end decisions
  always_comb begin
    img1 = fsrl_pkg::RST_BYTE;
    img1[fsrl_pkg::B1_LOCK] = q.lock;
    img1[fsrl_pkg::B1_FAIL] = q.fail;
    img1[fsrl_pkg::B1_GUARD] = wp_n_s;
    img1[fsrl_pkg::B1_SWP_HI:fsrl_pkg::B1_SWP_LO] = soft_protect_summary_i;
    img1[fsrl_pkg::B1_LATCH] = q.latch;
    img1[fsrl_pkg::B1_BUSY] = op_busy_i;
    img2 = fsrl_pkg::RST_BYTE;
    img2[fsrl_pkg::B2_RST_PERMIT] = q.rst_permit;
    img2[fsrl_pkg::B2_LD_PERMIT] = q.ld_permit;
    img2[fsrl_pkg::B2_PROG_PAUSED] = q.prog_paused;
    img2[fsrl_pkg::B2_ERASE_PAUSED] = q.erase_paused;
    img2[fsrl_pkg::B2_BUSY] = op_busy_i;
    rx_next = {q.rx[6:0], si_s};
    frame_end = cs_n_s && (q.st != fsrl_pkg::FSRL_IDLE);
    full_op = (q.st != fsrl_pkg::FSRL_OPCODE);
    aligned = (q.bit_cnt == 3'h0);
    wren_set = frame_end && full_op && aligned && (q.opcode == fsrl_pkg::OP_WRITE_ENABLE);
    wr_clear = frame_end && full_op && (is_write_cmd(q.opcode) || q.opcode == fsrl_pkg::OP_WRITE_DISABLE);
    wr1_apply = frame_end && full_op && aligned && q.data_seen && q.latch
      && (q.opcode == fsrl_pkg::OP_WRITE_BYTE1)
      && !(!wp_n_s && q.lock && !q.wdata[fsrl_pkg::B1_LOCK]);
    wr2_apply = frame_end && full_op && aligned && q.data_seen && q.latch
      && (q.opcode == fsrl_pkg::OP_WRITE_BYTE2);
    reset_ok = soft_reset_i && q.rst_permit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    d.gprot = 1'b0;
    if (op_end_i) begin
      d.fail = op_fail_i;
    end
    if (prog_resume_i || reset_ok) begin
      d.prog_paused = 1'b0;
    end
    if (prog_suspend_i) begin
      d.prog_paused = 1'b1;
    end
    if (erase_resume_i || reset_ok) begin
      d.erase_paused = 1'b0;
    end
    if (erase_suspend_i) begin
      d.erase_paused = 1'b1;
    end
    if (latch_clear_i || hold_abort_i || reset_ok || wr_clear) begin
      d.latch = 1'b0;
    end
    if (wren_set) begin
      d.latch = 1'b1;
    end
    if (wr1_apply) begin
      d.lock = q.wdata[fsrl_pkg::B1_LOCK];
      d.gprot = 1'b1;
    end
    if (wr2_apply) begin
      d.rst_permit = q.wdata[fsrl_pkg::B2_RST_PERMIT];
      if (!q.frozen) begin
        d.ld_permit = q.wdata[fsrl_pkg::B2_LD_PERMIT];
      end
    end
    if (freeze_done_i) begin
      d.frozen = 1'b1;
    end
    if (d.frozen) begin
      d.ld_permit = 1'b0;
    end
    if (cs_n_s) begin
      d.st = fsrl_pkg::FSRL_IDLE;
      d.so_oe = 1'b0;
      d.bit_cnt = 3'h0;
    end else begin
      unique case (q.st)
        fsrl_pkg::FSRL_IDLE: begin
          d.st = fsrl_pkg::FSRL_OPCODE;
          d.bit_cnt = 3'h0;
          d.data_seen = 1'b0;
        end
        fsrl_pkg::FSRL_OPCODE: begin
          if (sck_rise) begin
            d.rx = rx_next;
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == fsrl_pkg::LAST_BIT) begin
              d.opcode = rx_next;
              if (rx_next == fsrl_pkg::OP_READ_STATUS) begin
                d.st = fsrl_pkg::FSRL_READ;
                d.tx = img1;
                d.byte_sel = 1'b1;
              end else if (is_write_cmd(rx_next)) begin
                d.st = fsrl_pkg::FSRL_DATA;
              end else begin
                d.st = fsrl_pkg::FSRL_SKIP;
              end
            end
          end
        end
        fsrl_pkg::FSRL_READ: begin
          if (sck_fall) begin
            d.so = q.tx[7];
            d.so_oe = 1'b1;
            d.tx = {q.tx[6:0], 1'b0};
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == fsrl_pkg::LAST_BIT) begin
              d.tx = q.byte_sel ? img2 : img1;
              d.byte_sel = ~q.byte_sel;
            end
          end
        end
        fsrl_pkg::FSRL_DATA: begin
          if (sck_rise) begin
            d.rx = rx_next;
            d.bit_cnt = q.bit_cnt + 3'h1;
            if ((q.bit_cnt == fsrl_pkg::LAST_BIT) && !q.data_seen) begin
              d.wdata = rx_next;
              d.data_seen = 1'b1;
            end
          end
        end
        fsrl_pkg::FSRL_SKIP: begin
          if (sck_rise) begin
            d.bit_cnt = q.bit_cnt + 3'h1;
          end
        end
        default: d.st = fsrl_pkg::FSRL_IDLE;
      endcase
    end
    d.stat1 = img1;
    d.stat2 = img2;
    d.prot_ok = ~d.lock;
    d.ld_ok = d.ld_permit & d.latch;
    d.rst_ok = d.rst_permit;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{
        st: fsrl_pkg::FSRL_IDLE,
        bit_cnt: 3'h0,
        opcode: fsrl_pkg::RST_BYTE,
        rx: fsrl_pkg::RST_BYTE,
        tx: fsrl_pkg::RST_BYTE,
        wdata: fsrl_pkg::RST_BYTE,
        byte_sel: 1'b0,
        data_seen: 1'b0,
        lock: fsrl_pkg::RST_LOCK,
        fail: fsrl_pkg::RST_FAIL,
        latch: fsrl_pkg::RST_LATCH,
        rst_permit: fsrl_pkg::RST_RST_PERMIT,
        ld_permit: fsrl_pkg::RST_LD_PERMIT,
        frozen: 1'b0,
        prog_paused: fsrl_pkg::RST_PAUSED,
        erase_paused: fsrl_pkg::RST_PAUSED,
        so: 1'b0,
        so_oe: 1'b0,
        stat1: fsrl_pkg::RST_BYTE,
        stat2: fsrl_pkg::RST_BYTE,
        prot_ok: 1'b1,
        ld_ok: 1'b0,
        rst_ok: 1'b0,
        gprot: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign so_o = q.so;
  assign so_oe_o = q.so_oe;
  assign status_byte_one_o = q.stat1;
  assign status_byte_two_o = q.stat2;
  assign protect_regs_lock_o = q.lock;
  assign write_latch_o = q.latch;
  assign soft_reset_permit_o = q.rst_permit;
  assign lockdown_permit_o = q.ld_permit;
  assign protect_change_ok_o = q.prot_ok;
  assign lockdown_cmd_ok_o = q.ld_ok;
  assign reset_cmd_ok_o = q.rst_ok;
  assign global_protect_o = q.gprot;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  reserved_zero_a: assert property (status_byte_two_o[7:5] == 3'h0)
    else $error("reserved status bits not zero");
  busy_mirror_a: assert property (##1 status_byte_two_o[0] == $past(op_busy_i))
    else $error("busy bit does not follow busy input");
  guard_lock_a: assert property (q.lock && !wp_n_s |=> q.lock)
    else $error("lock cleared while guard pin asserted");
  fail_set_a: assert property (op_end_i && op_fail_i |=> q.fail ##1 status_byte_one_o[5])
    else $error("fail flag not set after failed operation");
  fail_abort_a: assert property (!op_end_i |=> $stable(q.fail))
    else $error("fail flag changed without operation end");
  latch_clear_a: assert property ((latch_clear_i || hold_abort_i) && !wren_set |=> !write_latch_o)
    else $error("write latch not cleared");
  partial_op_a: assert property (cs_n_s && q.st == fsrl_pkg::FSRL_OPCODE && !latch_clear_i && !hold_abort_i
    && !reset_ok |=> $stable(q.latch))
    else $error("latch touched by partial opcode");
  permit_hold_a: assert property (!wr2_apply |=> $stable(soft_reset_permit_o))
    else $error("reset permit changed without write");
  ld_permit_hold_a: assert property (!wr2_apply && !freeze_done_i |=> $stable(lockdown_permit_o))
    else $error("lockdown permit changed without write");
  freeze_perm_a: assert property (freeze_done_i |=> !lockdown_permit_o [*8])
    else $error("lockdown permit not forced low");
  write_latch_a: assert property (!q.latch |=> $stable(q.lock) && $stable(q.rst_permit))
    else $error("status write taken with latch clear");
  lock_reset_a: assert property (soft_reset_i && !wr1_apply |=> $stable(q.lock))
    else $error("soft reset changed lock");
  so_drive_a: assert property (so_oe_o |-> q.st == fsrl_pkg::FSRL_READ || $past(cs_n_s) == 1'b0)
    else $error("serial output driven outside status read");
  soft_reset_a: assert property (reset_ok && !prog_suspend_i && !erase_suspend_i && !wren_set
    |=> !write_latch_o && !q.prog_paused && !q.erase_paused)
    else $error("soft reset did not clear latch and suspends");
  lockdown_gate_a: assert property (lockdown_cmd_ok_o == (lockdown_permit_o && write_latch_o))
    else $error("lockdown allowed without permit");
  protect_gate_a: assert property (protect_change_ok_o == !protect_regs_lock_o)
    else $error("protect gate disagrees with lock");

endmodule

/* File: fsrl_host_model.sv */
// Host serial controller model that issues status commands
`timescale 1ns/1ns
module fsrl_host_model (
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One framed command in mode 0, MSB first; clock idles low between frames
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int nbits, output logic [31:0] rx);
    logic [39:0] tx;
    tx = {op, dat, 24'h000000};
    rx = 32'h00000000;
    // Start just after a rising edge of the system clock grid
    #((155 - $time % 100) % 100);
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si_o = tx[39 - i];
      #400 sck_o = 1'b1;
      // Sampled late in the high phase, where the synchronised output has settled
      #390 rx = {rx[30:0], so_oe_i ? so_i : 1'bx};
      #10 sck_o = 1'b0;
    end
    #400 cs_n_o = 1'b1;
    si_o = ~si_o;
    #1000;
  endtask
endmodule

/* File: tb_flash_status_register_logic.sv */
// Self-checking testbench of the flash status register logic
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_flash_status_register_logic;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic op_busy_i = 1'b0;
  logic op_fail_i = 1'b0;
  logic [1:0] soft_protect_summary_i = 2'h0;
  logic [8:0] ev = 9'h000;
  logic sck, cs_n, si, so_o, so_oe_o, global_protect_o;
  logic [7:0] status_byte_one_o, status_byte_two_o;
  logic protect_regs_lock_o, write_latch_o, soft_reset_permit_o, lockdown_permit_o;
  logic protect_change_ok_o, lockdown_cmd_ok_o, reset_cmd_ok_o;
  logic e_lock = 1'b0, e_fail = 1'b0, e_latch = 1'b0, e_rp = 1'b0, e_lp = 1'b0, e_pp = 1'b0, e_ep = 1'b0;
  logic [31:0] rx;
  logic [1:0] sum_tab [3] = '{2'h0, 2'h1, 2'h3};
  int error_cnt = 0;
  int samples_checked = 0;
  int gp_cnt = 0;
  int n;
  integer seed = 89661;
  integer tmp;
  always #50 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    if (global_protect_o === 1'b1) begin
      gp_cnt++;
    end
  end
  fsrl_host_model host (.so_i(so_o), .so_oe_i(so_oe_o), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
  fsrl_status_regs dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sck_i(sck),
    .cs_n_i(cs_n),
    .si_i(si),
    .wp_n_i(wp_n_i),
    .op_busy_i(op_busy_i),
    .op_end_i(ev[0]),
    .op_fail_i(op_fail_i),
    .latch_clear_i(ev[1]),
    .hold_abort_i(ev[2]),
    .soft_reset_i(ev[3]),
    .freeze_done_i(ev[4]),
    .prog_suspend_i(ev[5]),
    .prog_resume_i(ev[6]),
    .erase_suspend_i(ev[7]),
    .erase_resume_i(ev[8]),
    .soft_protect_summary_i(soft_protect_summary_i),
    .so_o(so_o),
    .so_oe_o(so_oe_o),
    .status_byte_one_o(status_byte_one_o),
    .status_byte_two_o(status_byte_two_o),
    .protect_regs_lock_o(protect_regs_lock_o),
    .write_latch_o(write_latch_o),
    .soft_reset_permit_o(soft_reset_permit_o),
    .lockdown_permit_o(lockdown_permit_o),
    .protect_change_ok_o(protect_change_ok_o),
    .lockdown_cmd_ok_o(lockdown_cmd_ok_o),
    .reset_cmd_ok_o(reset_cmd_ok_o),
    .global_protect_o(global_protect_o)
  );
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_one();
    return {e_lock, 1'b0, e_fail, wp_n_i, soft_protect_summary_i, e_latch, op_busy_i};
  endfunction
  function automatic logic [7:0] exp_two();
    return {3'h0, e_rp, e_lp, e_pp, e_ep, op_busy_i};
  endfunction
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_all();
    `CHK("byte_one", exp_one(), status_byte_one_o)
    `CHK("byte_two", exp_two(), status_byte_two_o)
    `CHK("latch", e_latch, write_latch_o)
    `CHK("levels", {e_lock, e_rp, e_lp}, {protect_regs_lock_o, soft_reset_permit_o, lockdown_permit_o})
    `CHK("prot_ok", ~e_lock, protect_change_ok_o)
    `CHK("ld_ok", e_lp & e_latch, lockdown_cmd_ok_o)
    `CHK("rst_ok", e_rp, reset_cmd_ok_o)
    `CHK("so_oe", 1'b0, so_oe_o)
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge clk_i);
    #5 ev = m;
    @(posedge clk_i);
    #5 ev = 9'h000;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d, input int nb);
    host.cmd(8'h06, 8'h00, 8, rx);
    host.cmd(op, d, nb, rx);
  endtask
  task automatic read_check();
    host.cmd(8'h05, 8'h00, 40, rx);
    `CHK("stream", {exp_one(), exp_two(), exp_one(), exp_two()}, rx)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #5000000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #5 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    check_all();
    host.cmd(8'h31, 8'hFF, 16, rx);
    check_all();
    host.cmd(8'h06, 8'h00, 8, rx);
    e_latch = 1'b1;
    check_all();
    host.cmd(8'h31, 8'h00, 4, rx);
    check_all();
    host.cmd(8'h31, 8'hFF, 16, rx);
    {e_rp, e_lp, e_latch} = 3'h6;
    check_all();
    wr(8'h31, 8'h00, 12);
    check_all();
    wr(8'h01, 8'h80, 16);
    e_lock = 1'b1;
    check_all();
    pulse(9'h020);
    e_pp = 1'b1;
    pulse(9'h080);
    e_ep = 1'b1;
    check_all();
    pulse(9'h040);
    e_pp = 1'b0;
    check_all();
    pulse(9'h020);
    host.cmd(8'h06, 8'h00, 8, rx);
    pulse(9'h008);
    {e_pp, e_ep} = 2'h0;
    check_all();
    @(posedge clk_i);
    #5 wp_n_i = 1'b0;
    wr(8'h01, 8'h00, 16);
    check_all();
    @(posedge clk_i);
    #5 wp_n_i = 1'b1;
    wr(8'h01, 8'h7F, 16);
    e_lock = 1'b0;
    check_all();
    @(posedge clk_i);
    #5 op_fail_i = 1'b1;
    pulse(9'h001);
    e_fail = 1'b1;
    check_all();
    host.cmd(8'h06, 8'h00, 8, rx);
    pulse(9'h002);
    check_all();
    host.cmd(8'h06, 8'h00, 8, rx);
    pulse(9'h004);
    check_all();
    @(posedge clk_i);
    #5 op_fail_i = 1'b0;
    pulse(9'h001);
    e_fail = 1'b0;
    check_all();
    @(posedge clk_i);
    #5 op_busy_i = 1'b1;
    repeat (4) @(posedge clk_i);
    read_check();
    @(posedge clk_i);
    #5 op_busy_i = 1'b0;
    n = 0;
    rx[0] = 1'b1;
    while (rx[0] !== 1'b0) begin
      if (n == 4) begin
        error_cnt++;
        close_out();
      end
      host.cmd(8'h05, 8'h00, 40, rx);
      n++;
    end
    host.cmd(8'h06, 8'h00, 8, rx);
    e_latch = 1'b1;
    check_all();
    pulse(9'h010);
    e_lp = 1'b0;
    check_all();
    wr(8'h31, 8'h18, 16);
    e_latch = 1'b0;
    check_all();
    @(posedge clk_i);
    #5 rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #5 rst_n_i = 1'b1;
    {e_lock, e_fail, e_latch, e_rp, e_lp, e_pp, e_ep} = 7'h00;
    repeat (4) @(posedge clk_i);
    check_all();
    host.cmd(8'h06, 8'h00, 8, rx);
    host.cmd(8'hA5, 8'h00, 16, rx);
    e_latch = 1'b1;
    check_all();
    host.cmd(8'h04, 8'h00, 8, rx);
    e_latch = 1'b0;
    check_all();
    wr(8'h31, 8'h08, 16);
    e_lp = 1'b1;
    check_all();
    for (int i = 0; i < 12; i++) begin
      tmp = $random(seed);
      @(posedge clk_i);
      #5 wp_n_i = tmp[0];
      soft_protect_summary_i = sum_tab[$unsigned(tmp) % 3];
      repeat (6) @(posedge clk_i);
      check_all();
      read_check();
    end
    `CHK("gprot_cnt", 2, gp_cnt)
    close_out();
  end
endmodule
